// *** pocl_pkg.sv ***
// Package of constants for the power-on configuration loader.
package pocl_pkg;
   // ****************************************************************
   // Memory map
   // ****************************************************************
   localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
   localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
   localparam logic [31:0] BRIDGE_A_BASE = 32'h4000_0000;
   localparam logic [31:0] BRIDGE_STRIDE = 32'h0100_0000;
   localparam logic [31:0] BRIDGE_SIZE = 32'h0001_0000;
   localparam logic [31:0] FLASH_SIZE = 32'h0004_0000;
   localparam logic [31:0] SRAM_SIZE = 32'h0000_8000;
   localparam logic [31:0] USER_ROW_ADDR = 32'h0080_4000;
   localparam logic [15:0] FLASH_PAGES = 16'h1000;
   localparam logic [2:0] PAGE_SIZE_CODE = 3'h0;
   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [7:0] REG_FLASH_PARAMETER = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_CFG_LO = 8'h08;
   localparam logic [7:0] REG_CFG_HI = 8'h0C;
   localparam logic [7:0] REG_ROW_LO = 8'h10;
   localparam logic [7:0] REG_ROW_HI = 8'h14;
   localparam logic [7:0] REG_CAL = 8'h18;
   localparam logic [7:0] REG_DECODE = 8'h1C;
   localparam logic [7:0] REG_REGION = 8'h20;
   localparam logic [4:0] PAGE_SIZE_POS = 5'h10;
   // ****************************************************************
   // User row field positions
   // ****************************************************************
   localparam int BOOTP_LSB = 0;
   localparam int EEP_LSB = 4;
   localparam int BLVL_LSB = 8;
   localparam int BEN_POS = 14;
   localparam int BACT_LSB = 15;
   localparam int WEN_POS = 25;
   localparam int WAO_POS = 26;
   localparam int WPER_LSB = 27;
   localparam int WWIN_LSB = 31;
   localparam int WEWO_LSB = 35;
   localparam int WWEN_POS = 39;
   localparam int BHYS_POS = 40;
   localparam int LOCK_LSB = 48;
   // Default row: lock FFFF, hyst 1, ewo B, win B, per B, act 1, en 1, lvl 7, eep 7, bootp 7.
   localparam logic [63:0] ROW_DEFAULT = 64'hFFFF_015D_D800_C777;
   localparam logic [2:0] BOOTP_ALT_DEFAULT = 3'h3;
   localparam logic [5:0] BLVL_AUTO_DEFAULT = 6'h22;
   localparam logic [31:0] CAL_DEFAULT = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   typedef enum logic [2:0] {ST_POR, ST_CAL, ST_ROW0, ST_ROW1, ST_APPLY, ST_RUN} pocl_state_e;
endpackage

// *** pocl_loader.sv ***
// Power-on configuration loader with AXI4-Lite status and decode registers.
// Notes on behaviour
// - Analog supply reset monitor always active; low supply restarts the load and consumer reset, but loaded values and bus registers keep theirs.
// - Core supply brown-out monitoring starts only after startup completes.
// - Fixed address map decode: flash, SRAM, three 64 KB bridge windows, no remap.
// - Report flash page count and page size read-only; 64-byte pages, four per row.
// - Copy automatic calibration row values into their registers at startup.
// - Read first two 32-bit user row words at power-on and apply them.
// - User row readable through the REG_ROW_LO and REG_ROW_HI registers; its fixed address is only decoded as region 6.
// - Rewritten user row takes effect only at next device reset.
// - Boot protect size from bits 2:0, default 7, or 3 on one variant.
// - Emulated EEPROM size from bits 6:4, default 7.
// - Analog brown-out level from bits 13:8, default 7, or 34 automotive grade.
// - Analog brown-out enable from bit 14, default 1.
// - Analog brown-out action from bits 16:15, default 1.
// - Analog brown-out hysteresis from bit 40, default 1.
// - Watchdog enable bit 25, always-on bit 26, both default 0.
// - Watchdog period from bits 30:27, default 0x0B.
// - Watchdog window timeout from bits 34:31, default 0x0B.
// - Watchdog early warning offset from bits 38:35, default 0xB.
// - Watchdog window enable from bit 39, default 0.
// - Flash region lock bits from bits 63:48, default 0xFFFF.
`timescale 1ns/1ps
module pocl_loader
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic ANALOG_SUPPLY_OK,
   input wire logic CORE_SUPPLY_OK,
   input wire logic ROW_BLANK,
   input wire logic VARIANT_ALT,
   input wire logic GRADE_AUTO,
   output logic NVM_REQ,
   output logic [1:0] NVM_SEL,
   input wire logic NVM_ACK,
   input wire logic [31:0] NVM_DATA,
   output logic CONSUMER_NRST,
   output logic CORE_BOD_EN,
   output logic CORE_BOD_RESET,
   output logic [31:0] CAL_VALUE,
   output logic [2:0] BOOT_PROTECT_SIZE,
   output logic [2:0] EEPROM_SIZE,
   output logic [5:0] ANALOG_SUPPLY_BROWNOUT_LEVEL,
   output logic ANALOG_SUPPLY_BROWNOUT_EN,
   output logic [1:0] ANALOG_SUPPLY_BROWNOUT_ACTION,
   output logic ANALOG_SUPPLY_BROWNOUT_HYST,
   output logic WATCHDOG_UNIT_EN,
   output logic WATCHDOG_UNIT_ALWAYS_ON,
   output logic [3:0] WATCHDOG_UNIT_PERIOD,
   output logic [3:0] WATCHDOG_UNIT_WINDOW,
   output logic [3:0] EARLY_WARNING_OFFSET,
   output logic WATCHDOG_UNIT_WIN_EN,
   output logic [15:0] REGION_LOCK,
   input wire logic [31:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [31:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY
);
   // ****************************************************************
   // Supply synchronisers and chip reset
   // ****************************************************************
   logic [1:0] ana_sync_ff;
   logic [1:0] core_sync_ff;
   logic [1:0] blank_sync_ff;
   logic [1:0] alt_sync_ff;
   logic [1:0] auto_sync_ff;
   logic chip_nrst;
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         ana_sync_ff <= 2'h0;
         core_sync_ff <= 2'h0;
         blank_sync_ff <= 2'h0;
         alt_sync_ff <= 2'h0;
         auto_sync_ff <= 2'h0;
      end
      else
      begin
         ana_sync_ff <= {ana_sync_ff[0], ANALOG_SUPPLY_OK};
         core_sync_ff <= {core_sync_ff[0], CORE_SUPPLY_OK};
         blank_sync_ff <= {blank_sync_ff[0], ROW_BLANK};
         alt_sync_ff <= {alt_sync_ff[0], VARIANT_ALT};
         auto_sync_ff <= {auto_sync_ff[0], GRADE_AUTO};
      end
   end
   // Low analog supply sends the load sequence back to ST_POR and holds the consumer reset and core monitor off.
   assign chip_nrst = ana_sync_ff[1];
   // ****************************************************************
   // Load sequence
   // ****************************************************************
   pocl_pkg::pocl_state_e state_ff;
   pocl_pkg::pocl_state_e nxt_state;
   logic [31:0] cal_ff;
   logic [63:0] row_ff;
   logic [63:0] cfg_ff;
   logic [63:0] eff_row;
   logic [63:0] dflt_row;
   logic req_ff;
   logic [1:0] sel_ff;
   logic cons_nrst_ff;
   logic bod_en_ff;
   logic bod_rst_ff;
   logic strap_alt_ff;
   logic strap_auto_ff;
   logic busy;
   assign busy = (state_ff == pocl_pkg::ST_CAL) || (state_ff == pocl_pkg::ST_ROW0) ||
                 (state_ff == pocl_pkg::ST_ROW1);
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         pocl_pkg::ST_POR: nxt_state = pocl_pkg::ST_CAL;
         pocl_pkg::ST_CAL: if (NVM_ACK) nxt_state = pocl_pkg::ST_ROW0;
         pocl_pkg::ST_ROW0: if (NVM_ACK) nxt_state = pocl_pkg::ST_ROW1;
         pocl_pkg::ST_ROW1: if (NVM_ACK) nxt_state = pocl_pkg::ST_APPLY;
         pocl_pkg::ST_APPLY: nxt_state = pocl_pkg::ST_RUN;
         pocl_pkg::ST_RUN: nxt_state = pocl_pkg::ST_RUN;
         default: nxt_state = pocl_pkg::ST_POR;
      endcase
   end
   // Defaults for a blank row, with the package and grade straps folded in.
   assign dflt_row = {pocl_pkg::ROW_DEFAULT[63:14],
                      strap_auto_ff ? pocl_pkg::BLVL_AUTO_DEFAULT : pocl_pkg::ROW_DEFAULT[13:8],
                      pocl_pkg::ROW_DEFAULT[7:3],
                      strap_alt_ff ? pocl_pkg::BOOTP_ALT_DEFAULT : pocl_pkg::ROW_DEFAULT[2:0]};
   assign eff_row = blank_sync_ff[1] ? dflt_row : row_ff;
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         state_ff <= pocl_pkg::ST_POR;
         cal_ff <= pocl_pkg::CAL_DEFAULT;
         row_ff <= pocl_pkg::ROW_DEFAULT;
         cfg_ff <= pocl_pkg::ROW_DEFAULT;
         req_ff <= 1'b0;
         sel_ff <= 2'h0;
         cons_nrst_ff <= 1'b0;
         bod_en_ff <= 1'b0;
         bod_rst_ff <= 1'b0;
         strap_alt_ff <= 1'b0;
         strap_auto_ff <= 1'b0;
      end
      else if (!chip_nrst)
      begin
         state_ff <= pocl_pkg::ST_POR;
         cons_nrst_ff <= 1'b0;
         bod_en_ff <= 1'b0;
         bod_rst_ff <= 1'b0;
         req_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         // Straps are followed during the load, when their synchronisers have settled.
         if (busy)
         begin
            strap_alt_ff <= alt_sync_ff[1];
            strap_auto_ff <= auto_sync_ff[1];
         end
         req_ff <= (nxt_state == pocl_pkg::ST_CAL) || (nxt_state == pocl_pkg::ST_ROW0) ||
                   (nxt_state == pocl_pkg::ST_ROW1);
         sel_ff <= (nxt_state == pocl_pkg::ST_ROW0) ? 2'h1 : (nxt_state == pocl_pkg::ST_ROW1) ? 2'h2 : 2'h0;
         if (busy && NVM_ACK && state_ff == pocl_pkg::ST_CAL)
            cal_ff <= NVM_DATA;
         if (busy && NVM_ACK && state_ff == pocl_pkg::ST_ROW0)
            row_ff[31:0] <= NVM_DATA;
         if (busy && NVM_ACK && state_ff == pocl_pkg::ST_ROW1)
            row_ff[63:32] <= NVM_DATA;
         // Configuration is latched once per reset, so a rewritten row waits for the next one.
         if (state_ff == pocl_pkg::ST_APPLY)
            cfg_ff <= eff_row;
         cons_nrst_ff <= (state_ff == pocl_pkg::ST_APPLY) || (state_ff == pocl_pkg::ST_RUN);
         bod_en_ff <= (state_ff == pocl_pkg::ST_RUN);
         bod_rst_ff <= (state_ff == pocl_pkg::ST_RUN) && !core_sync_ff[1];
      end
   end
   assign NVM_REQ = req_ff;
   assign NVM_SEL = sel_ff;
   assign CONSUMER_NRST = cons_nrst_ff;
   assign CORE_BOD_EN = bod_en_ff;
   assign CORE_BOD_RESET = bod_rst_ff;
   assign CAL_VALUE = cal_ff;
   // ****************************************************************
   // Configuration fields
   // ****************************************************************
   assign BOOT_PROTECT_SIZE = cfg_ff[pocl_pkg::BOOTP_LSB +: 3];
   assign EEPROM_SIZE = cfg_ff[pocl_pkg::EEP_LSB +: 3];
   assign ANALOG_SUPPLY_BROWNOUT_LEVEL = cfg_ff[pocl_pkg::BLVL_LSB +: 6];
   assign ANALOG_SUPPLY_BROWNOUT_EN = cfg_ff[pocl_pkg::BEN_POS];
   assign ANALOG_SUPPLY_BROWNOUT_ACTION = cfg_ff[pocl_pkg::BACT_LSB +: 2];
   assign ANALOG_SUPPLY_BROWNOUT_HYST = cfg_ff[pocl_pkg::BHYS_POS];
   assign WATCHDOG_UNIT_EN = cfg_ff[pocl_pkg::WEN_POS];
   assign WATCHDOG_UNIT_ALWAYS_ON = cfg_ff[pocl_pkg::WAO_POS];
   assign WATCHDOG_UNIT_PERIOD = cfg_ff[pocl_pkg::WPER_LSB +: 4];
   assign WATCHDOG_UNIT_WINDOW = cfg_ff[pocl_pkg::WWIN_LSB +: 4];
   assign EARLY_WARNING_OFFSET = cfg_ff[pocl_pkg::WEWO_LSB +: 4];
   assign WATCHDOG_UNIT_WIN_EN = cfg_ff[pocl_pkg::WWEN_POS];
   assign REGION_LOCK = cfg_ff[pocl_pkg::LOCK_LSB +: 16];
   // ****************************************************************
   // Register bus
   // ****************************************************************
   // Region code of an address: 1 flash, 2 SRAM, 3-5 bridge A-C, 6 user row, 0 none.
   function automatic logic [2:0] region_of(input logic [31:0] a);
      logic [2:0] r;
      r = 3'h0;
      if (a - pocl_pkg::FLASH_BASE < pocl_pkg::FLASH_SIZE) r = 3'h1;
      else if (a - pocl_pkg::SRAM_BASE < pocl_pkg::SRAM_SIZE) r = 3'h2;
      else if (a - pocl_pkg::BRIDGE_A_BASE < pocl_pkg::BRIDGE_SIZE) r = 3'h3;
      else if (a - pocl_pkg::BRIDGE_A_BASE - pocl_pkg::BRIDGE_STRIDE < pocl_pkg::BRIDGE_SIZE) r = 3'h4;
      else if (a - pocl_pkg::BRIDGE_A_BASE - (pocl_pkg::BRIDGE_STRIDE << 1) < pocl_pkg::BRIDGE_SIZE) r = 3'h5;
      else if ((a & 32'hFFFF_FFF8) == pocl_pkg::USER_ROW_ADDR) r = 3'h6;
      return r;
   endfunction
   logic [31:0] probe_ff;
   logic [2:0] region_w;
   logic [31:0] status_w;
   logic [31:0] rd_word;
   logic rd_hit;
   logic aw_got_ff;
   logic w_got_ff;
   logic [7:0] awaddr_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic [7:0] ra;
   logic [31:0] wdata_hold_ff;
   logic nxt_aw_got;
   logic nxt_w_got;
   logic nxt_bvalid;
   logic nxt_rvalid;
   logic awready_ff;
   logic wready_ff;
   logic arready_ff;
   assign region_w = region_of(probe_ff);
   assign status_w = {24'h0, cons_nrst_ff, bod_en_ff, blank_sync_ff[1], 2'h0, state_ff};
   assign ra = ARADDR[7:0];
   assign rd_hit = ARADDR[31:8] == 24'h0 && (ra == pocl_pkg::REG_FLASH_PARAMETER || ra == pocl_pkg::REG_STATUS ||
                   ra == pocl_pkg::REG_CFG_LO || ra == pocl_pkg::REG_CFG_HI || ra == pocl_pkg::REG_ROW_LO ||
                   ra == pocl_pkg::REG_ROW_HI || ra == pocl_pkg::REG_CAL || ra == pocl_pkg::REG_DECODE ||
                   ra == pocl_pkg::REG_REGION);
   assign rd_word = (ra == pocl_pkg::REG_FLASH_PARAMETER) ?
                    ({13'h0, pocl_pkg::PAGE_SIZE_CODE, pocl_pkg::FLASH_PAGES} ) :
                    (ra == pocl_pkg::REG_STATUS) ? status_w :
                    (ra == pocl_pkg::REG_CFG_LO) ? cfg_ff[31:0] :
                    (ra == pocl_pkg::REG_CFG_HI) ? cfg_ff[63:32] :
                    (ra == pocl_pkg::REG_ROW_LO) ? row_ff[31:0] :
                    (ra == pocl_pkg::REG_ROW_HI) ? row_ff[63:32] :
                    (ra == pocl_pkg::REG_CAL) ? cal_ff :
                    (ra == pocl_pkg::REG_DECODE) ? probe_ff : {29'h0, region_w};
   // Next handshake state, so that the ready outputs can leave straight from flops.
   assign nxt_bvalid = bvalid_ff ? !BREADY : (aw_got_ff && w_got_ff);
   assign nxt_aw_got = aw_got_ff ? !(w_got_ff && !bvalid_ff) : (AWVALID && !bvalid_ff);
   assign nxt_w_got = w_got_ff ? !(aw_got_ff && !bvalid_ff) : (WVALID && !bvalid_ff);
   assign nxt_rvalid = rvalid_ff ? !RREADY : ARVALID;
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         awaddr_ff <= 8'h00;
         bvalid_ff <= 1'b0;
         bresp_ff <= pocl_pkg::RESP_OKAY;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= pocl_pkg::RESP_OKAY;
         probe_ff <= 32'h0000_0000;
      end
      else
      begin
         if (bvalid_ff && BREADY)
            bvalid_ff <= 1'b0;
         if (AWVALID && !aw_got_ff && !bvalid_ff)
         begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= (AWADDR[31:8] == 24'h0) ? AWADDR[7:0] : 8'hFF;
         end
         if (WVALID && !w_got_ff && !bvalid_ff)
            w_got_ff <= 1'b1;
         if (aw_got_ff && w_got_ff && !bvalid_ff)
         begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            if (awaddr_ff == pocl_pkg::REG_DECODE)
            begin
               probe_ff <= wdata_hold_ff;
               bresp_ff <= pocl_pkg::RESP_OKAY;
            end
            else
               bresp_ff <= pocl_pkg::RESP_SLVERR;
         end
         if (rvalid_ff && RREADY)
            rvalid_ff <= 1'b0;
         if (ARVALID && !rvalid_ff)
         begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_hit ? rd_word : 32'h0000_0000;
            rresp_ff <= rd_hit ? pocl_pkg::RESP_OKAY : pocl_pkg::RESP_DECERR;
         end
      end
   end
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         wdata_hold_ff <= 32'h0000_0000;
      else if (WVALID && !w_got_ff && !bvalid_ff)
         wdata_hold_ff <= {WSTRB[3] ? WDATA[31:24] : probe_ff[31:24], WSTRB[2] ? WDATA[23:16] : probe_ff[23:16],
                           WSTRB[1] ? WDATA[15:8] : probe_ff[15:8], WSTRB[0] ? WDATA[7:0] : probe_ff[7:0]};
   end
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
         arready_ff <= 1'b1;
      end
      else
      begin
         awready_ff <= !nxt_aw_got && !nxt_bvalid;
         wready_ff <= !nxt_w_got && !nxt_bvalid;
         arready_ff <= !nxt_rvalid;
      end
   end
   assign AWREADY = awready_ff;
   assign WREADY = wready_ff;
   assign BVALID = bvalid_ff;
   assign BRESP = bresp_ff;
   assign ARREADY = arready_ff;
   assign RVALID = rvalid_ff;
   assign RDATA = rdata_ff;
   assign RRESP = rresp_ff;
   // ****************************************************************
   // Assertions
   // ****************************************************************
   consumer_gate_a: assert property (@(posedge CLK) disable iff (!NRST)
      $rose(cons_nrst_ff) |-> $past(state_ff) == pocl_pkg::ST_APPLY || $past(state_ff) == pocl_pkg::ST_RUN)
      else $error("Consumer reset released before load.");
   por_reset_a: assert property (@(posedge CLK) disable iff (!NRST)
      !ana_sync_ff[1] |=> !cons_nrst_ff && state_ff == pocl_pkg::ST_POR)
      else $error("Low analog supply did not reset.");
   core_bod_a: assert property (@(posedge CLK) disable iff (!NRST)
      bod_en_ff |-> cons_nrst_ff && $past(state_ff) == pocl_pkg::ST_RUN)
      else $error("Core monitor enabled before startup.");
   cfg_hold_a: assert property (@(posedge CLK) disable iff (!NRST)
      state_ff == pocl_pkg::ST_RUN && $past(state_ff) == pocl_pkg::ST_RUN |-> $stable(cfg_ff))
      else $error("Configuration changed while running.");
   lock_field_a: assert property (@(posedge CLK) disable iff (!NRST)
      $past(state_ff) == pocl_pkg::ST_APPLY && $past(chip_nrst) |-> REGION_LOCK == $past(eff_row[63:48]))
      else $error("Lock bits not applied.");
   row_load_a: assert property (@(posedge CLK) disable iff (!NRST)
      state_ff == pocl_pkg::ST_ROW1 && NVM_ACK && chip_nrst |=> row_ff[63:32] == $past(NVM_DATA))
      else $error("Second row word not captured.");
   cal_load_a: assert property (@(posedge CLK) disable iff (!NRST)
      state_ff == pocl_pkg::ST_CAL && NVM_ACK && chip_nrst |=> CAL_VALUE == $past(NVM_DATA))
      else $error("Calibration word not captured.");
   bridge_decode_a: assert property (@(posedge CLK) disable iff (!NRST)
      probe_ff[31:24] == 8'h41 && probe_ff[23:16] == 8'h00 |-> region_w == 3'h4)
      else $error("Bridge B window misdecoded.");
   blank_lock_a: assert property (@(posedge CLK) disable iff (!NRST)
      $past(state_ff) == pocl_pkg::ST_APPLY && $past(chip_nrst) && $past(blank_sync_ff[1]) |->
      REGION_LOCK == pocl_pkg::ROW_DEFAULT[63:48])
      else $error("Blank row lock default not applied.");
   boot_alt_a: assert property (@(posedge CLK) disable iff (!NRST)
      $past(state_ff) == pocl_pkg::ST_APPLY && $past(chip_nrst) && $past(blank_sync_ff[1]) &&
      $past(strap_alt_ff) |-> BOOT_PROTECT_SIZE == pocl_pkg::BOOTP_ALT_DEFAULT)
      else $error("Variant boot protect default not applied.");
   level_auto_a: assert property (@(posedge CLK) disable iff (!NRST)
      $past(state_ff) == pocl_pkg::ST_APPLY && $past(chip_nrst) && $past(blank_sync_ff[1]) &&
      $past(strap_auto_ff) |-> ANALOG_SUPPLY_BROWNOUT_LEVEL == pocl_pkg::BLVL_AUTO_DEFAULT)
      else $error("Grade brown-out level default not applied.");
endmodule

// *** pocl_nvm_model.sv ***
// Behavioural model of the nonvolatile configuration rows.
`timescale 1ns/1ps
module pocl_nvm_model
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic req,
   input wire logic [1:0] sel,
   input wire logic [3:0] dly,
   input wire logic [31:0] cal_word,
   input wire logic [63:0] row,
   output logic ack,
   output logic [31:0] data
);
   logic [3:0] cnt_ff;
   logic [31:0] word;
   assign word = (sel == 2'h0) ? cal_word : (sel == 2'h1) ? row[31:0] : row[63:32];
   // The data lines are not held outside the answer cycle, so they toggle.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_ff <= 4'h0;
         ack <= 1'b0;
         data <= 32'h5A5A_A5A5;
      end
      else if (!ack && req && cnt_ff >= dly)
      begin
         ack <= 1'b1;
         data <= word;
      end
      else
      begin
         ack <= 1'b0;
         cnt_ff <= (req && !ack) ? cnt_ff + 4'h1 : 4'h0;
         data <= ~data;
      end
   end
endmodule

// *** tb_top.sv ***
// Self-checking testbench for the power-on configuration loader.
`timescale 1ns/1ps
module tb_top;
   // ****************************************************************
   // Signals
   // ****************************************************************
   localparam logic [63:0] DEF = 64'hFFFF_015D_D800_C777;
   localparam logic [63:0] ROW_A = 64'h1234_00AC_9E01_2A25;
   localparam logic [63:0] ROW_B = 64'h00FF_015D_D800_C777;
   localparam logic [31:0] CALW = 32'h3C5A_0F96;
   logic clk, nrst, ana_ok, core_ok, blank, alt, auto, req, ack, cnrst, bod_en, bod_rst;
   logic ben, bhys, wen, wao, wwen, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] sel, bact, bresp, rresp;
   logic [2:0] bps, eep;
   logic [3:0] dly, wper, wwin, wewo, wstrb;
   logic [5:0] lvl;
   logic [15:0] lock;
   logic [31:0] ndata, cal, awaddr, wdata, araddr, rdata;
   logic [63:0] row;
   logic [31:0] probe [12] = '{32'h0, 32'h0003_FFFC, 32'h0004_0000, 32'h2000_0000, 32'h2000_8000,
      32'h4000_0000, 32'h4000_FFFC, 32'h4001_0000, 32'h4100_0000, 32'h4200_0000, 32'h0080_4000, 32'h6000_0000};
   logic [31:0] region [12] = '{1, 1, 0, 2, 0, 3, 3, 0, 4, 5, 6, 0};
   int errors;
   int n_tests;
   pocl_nvm_model i_pocl_nvm_model (.clk(clk), .nrst(nrst), .req(req), .sel(sel), .dly(dly),
      .cal_word(CALW), .row(row), .ack(ack), .data(ndata));
   pocl_loader i_pocl_loader (.CLK(clk), .NRST(nrst), .ANALOG_SUPPLY_OK(ana_ok), .CORE_SUPPLY_OK(core_ok),
      .ROW_BLANK(blank), .VARIANT_ALT(alt), .GRADE_AUTO(auto), .NVM_REQ(req), .NVM_SEL(sel),
      .NVM_ACK(ack), .NVM_DATA(ndata), .CONSUMER_NRST(cnrst), .CORE_BOD_EN(bod_en), .CORE_BOD_RESET(bod_rst),
      .CAL_VALUE(cal), .BOOT_PROTECT_SIZE(bps), .EEPROM_SIZE(eep), .ANALOG_SUPPLY_BROWNOUT_LEVEL(lvl),
      .ANALOG_SUPPLY_BROWNOUT_EN(ben), .ANALOG_SUPPLY_BROWNOUT_ACTION(bact), .ANALOG_SUPPLY_BROWNOUT_HYST(bhys),
      .WATCHDOG_UNIT_EN(wen), .WATCHDOG_UNIT_ALWAYS_ON(wao), .WATCHDOG_UNIT_PERIOD(wper),
      .WATCHDOG_UNIT_WINDOW(wwin), .EARLY_WARNING_OFFSET(wewo), .WATCHDOG_UNIT_WIN_EN(wwen),
      .REGION_LOCK(lock), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
      .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
      .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
      .RVALID(rvalid), .RREADY(rready));
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         n_tests++;
         if (got !== exp)
         begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task automatic report_and_stop;
      begin
         if (errors == 0 && n_tests > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      begin
         @(posedge clk);
         awaddr <= a;
         awvalid <= 1'b1;
         wdata <= d;
         wvalid <= 1'b1;
         bready <= 1'b1;
         do
         begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
         end while ((awvalid && awready !== 1'b1) || (wvalid && wready !== 1'b1));
         @(posedge clk);
         while (bvalid !== 1'b1) @(posedge clk);
         r = bresp;
         bready <= 1'b0;
      end
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
      begin
         @(posedge clk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         @(posedge clk);
         while (arready !== 1'b1) @(posedge clk);
         arvalid <= 1'b0;
         @(posedge clk);
         while (rvalid !== 1'b1) @(posedge clk);
         rready <= 1'b0;
         chk(rdata, ed);
         chk(rresp, er);
      end
   endtask
   task automatic wait_run;
      int n;
      int acks;
      begin
         n = 0;
         acks = 0;
         while (cnrst !== 1'b1 && n < 300)
         begin
            @(posedge clk);
            if (ack === 1'b1) acks++;
            if (cnrst !== 1'b1) chk(bod_en, 0);
            n++;
         end
         chk(cnrst, 1);
         chk(acks, 3);
         repeat (2) @(posedge clk);
         chk(bod_en, 1);
      end
   endtask
   task automatic boot(input logic [3:0] d);
      begin
         @(posedge clk);
         dly <= d;
         nrst <= 1'b0;
         repeat (8) @(posedge clk);
         nrst <= 1'b1;
         wait_run();
      end
   endtask
   task automatic check_cfg(input logic [63:0] e);
      begin
         chk(bps, e[2:0]);
         chk(eep, e[6:4]);
         chk(lvl, e[13:8]);
         chk(ben, e[14]);
         chk(bact, e[16:15]);
         chk(bhys, e[40]);
         chk({wao, wen}, e[26:25]);
         chk(wper, e[30:27]);
         chk(wwin, e[34:31]);
         chk(wewo, e[38:35]);
         chk(wwen, e[39]);
         chk(lock, e[63:48]);
      end
   endtask
   task automatic t_blank;
      logic [63:0] e;
      begin
         blank <= 1'b1;
         alt <= 1'b1;
         auto <= 1'b1;
         boot(4'h0);
         e = DEF;
         e[2:0] = 3'h3;
         e[13:8] = 6'h22;
         check_cfg(e);
         alt <= 1'b0;
         auto <= 1'b0;
         boot(4'h1);
         check_cfg(DEF);
         blank <= 1'b0;
      end
   endtask
   task automatic t_bus;
      logic [1:0] r;
      begin
         rd_chk(32'h00, 32'h0000_1000, 2'h0);
         axi_wr(32'h00, 32'hFFFF_FFFF, r);
         chk(r, 2'h2);
         rd_chk(32'h00, 32'h0000_1000, 2'h0);
         rd_chk(32'h10, ROW_A[31:0], 2'h0);
         rd_chk(32'h14, ROW_A[63:32], 2'h0);
         rd_chk(32'h18, CALW, 2'h0);
         rd_chk(32'h40, 32'h0, 2'h3);
         for (int i = 0; i < 12; i++)
         begin
            axi_wr(32'h1C, probe[i], r);
            chk(r, 2'h0);
            rd_chk(32'h20, region[i], 2'h0);
         end
         wstrb <= 4'h1;
         axi_wr(32'h1C, 32'h1234_5678, r);
         wstrb <= 4'hF;
         chk(r, 2'h0);
         rd_chk(32'h1C, 32'h6000_0078, 2'h0);
         rd_chk(32'h08, ROW_A[31:0], 2'h0);
         rd_chk(32'h0C, ROW_A[63:32], 2'h0);
      end
   endtask
   task automatic t_supply;
      begin
         core_ok <= 1'b0;
         repeat (5) @(posedge clk);
         chk(bod_rst, 1);
         core_ok <= 1'b1;
         repeat (5) @(posedge clk);
         chk(bod_rst, 0);
         row <= ROW_A;
         ana_ok <= 1'b0;
         repeat (6) @(posedge clk);
         chk(cnrst, 0);
         ana_ok <= 1'b1;
         wait_run();
         check_cfg(ROW_A);
      end
   endtask
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      report_and_stop();
   end
   initial
   begin
      {nrst, awvalid, wvalid, bready, arvalid, rready, blank, alt, auto} = '0;
      {ana_ok, core_ok} = 2'b11;
      {awaddr, wdata, araddr} = '0;
      wstrb = 4'hF;
      dly = 4'h0;
      row = ROW_A;
      errors = 0;
      n_tests = 0;
      boot(4'h3);
      check_cfg(ROW_A);
      chk(cal, CALW);
      t_bus();
      row <= ROW_B;
      repeat (20) @(posedge clk);
      check_cfg(ROW_A);
      boot(4'h9);
      check_cfg(ROW_B);
      t_supply();
      t_blank();
      report_and_stop();
   end
endmodule
